// File: hw/sps_parallel_port.sv
// Parallel host port clocking and status logic of the serializer/deserializer.
// Assumes the clock and character pins arrive asynchronously to ref_clk and are sampled here,
// and that the register port master runs on ref_clk.
//
// How it works
// - Transmit clock output changes only on reference-clock derived character ticks.
// - Transmit clock output at reference rate when rate select 0, double when 1.
// - No fixed phase between transmit clock output and reference clock is promised.
// - Full-rate receive clock pair complementary; data changes after true clock rises.
// - Half-rate receive clock pair at half character rate; data changes on both edges.
// - Self-test enabled puts status on receive data bits one and zero and status pin.
// - Status pin shows self-test reception state when self-test control equals 10.
// - Reclocker powered-down flag high when both reclocker output enables are zero.
// - Half-rate reference clocking samples transmit data on both reference edges.
// - Half-rate reference clocking presents transmit error on both reference edges.
// - Receive interface clock runs continuously at the rate the rate select chooses.
// - Transmit data captured on rising edge of the clock the source select picks, on both reference edges in half rate.
//
// The implementer's own choices: the register offsets and the strobed register port.
`timescale 1ns/1ps

module sps_parallel_port
    import sps_pkg::*;
(
    input  wire logic        ref_clk,                     // System clock, 200 MHz.
    input  wire logic        rst_n,                       // Synchronous reset, active low.
    input  wire logic        tx_reference_clock,          // Transmit reference clock pin.
    input  wire logic        tx_interface_clock,          // Transmit interface clock pin.
    input  wire logic [9:0]  tx_parallel_data,            // Transmit character pins.
    input  wire logic        tx_fault,                    // Phase buffer fault, ref_clk domain.
    input  wire logic        rx_recovered_clock,          // Recovered character clock pin.
    input  wire logic [9:0]  rx_char_data,                // Recovered character, recovered domain.
    input  wire logic [2:0]  selftest_state,              // Self-test status code, ref_clk domain.
    input  wire logic [3:0]  reg_addr,                    // Register byte address.
    input  wire logic [31:0] reg_wdata,                   // Register write data.
    input  wire logic        reg_write,                   // Write strobe.
    input  wire logic        reg_read,                    // Read strobe.
    output logic      [31:0] reg_rdata,                   // Read data, cycle after the strobe.
    output logic             irq,                         // Level interrupt.
    output logic             tx_clock_out,                // Transmit clock output.
    output logic             tx_error_flag,               // Transmit error output.
    output sps_txword_t      tx_word,                     // Captured transmit character.
    output logic             rx_interface_clock,          // Receive clock, true.
    output logic             rx_interface_clock_n,        // Receive clock, complement.
    output logic      [9:0]  rx_parallel_data,            // Receive data output.
    output logic             selftest_status_out,         // Self-test status output.
    output logic             reclocker_powered_down_flag  // Reclocker powered down.
);

    sps_ctrl_t             ctrl;
    logic [SPS_EV_W-1:0]   status;
    logic [SPS_EV_W-1:0]   mask;
    logic [1:0]            refSync;
    logic [1:0]            txIfSync;
    logic [1:0]            rxRecSync;
    logic [9:0]            txDataMeta;
    logic [9:0]            txDataSync;
    logic [9:0]            rxDataMeta;
    logic [9:0]            rxDataSync;
    logic                  refLast;
    logic                  txIfLast;
    logic                  rxRecLast;
    logic [SPS_HALF_W-1:0] halfCnt;
    logic [SPS_HALF_W-1:0] halfLen;
    logic                  rxTick;
    logic                  txErrLast;
    logic                  pdownLast;
    logic                  bistLast;

    // Pin synchronisers; the first stage feeds only the second.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            refSync    <= 2'h0;
            txIfSync   <= 2'h0;
            rxRecSync  <= 2'h0;
            txDataMeta <= 10'h000;
            txDataSync <= 10'h000;
            rxDataMeta <= 10'h000;
            rxDataSync <= 10'h000;
        end
        else
        begin
            refSync    <= {refSync[0], tx_reference_clock};
            txIfSync   <= {txIfSync[0], tx_interface_clock};
            rxRecSync  <= {rxRecSync[0], rx_recovered_clock};
            txDataMeta <= tx_parallel_data;
            txDataSync <= txDataMeta;
            rxDataMeta <= rx_char_data;
            rxDataSync <= rxDataMeta;
        end
    end

    // Edge history of the synchronised clocks.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            refLast   <= 1'b0;
            txIfLast  <= 1'b0;
            rxRecLast <= 1'b0;
        end
        else
        begin
            refLast   <= refSync[1];
            txIfLast  <= txIfSync[1];
            rxRecLast <= rxRecSync[1];
        end
    end

    // Edge detection on the second synchroniser stage only.
    wire refRise  = refSync[1] & ~refLast;
    wire refFall  = ~refSync[1] & refLast;
    wire refEdge  = refRise | refFall;
    wire txIfRise = txIfSync[1] & ~txIfLast;
    wire rxRise   = rxRecSync[1] & ~rxRecLast;

    // Midpoint of a reference half period; a half period shorter than two cycles has no midpoint.
    wire midTick = ctrl.txRate & ~refEdge & (halfLen >= SPS_HALF_W'(2)) & (halfCnt == (halfLen >> 1));

    // Half-period measurement of the reference clock, saturating for a stopped clock.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            halfCnt <= '0;
            halfLen <= '0;
        end
        else if (refEdge)
        begin
            halfCnt <= SPS_HALF_W'(1);
            halfLen <= halfCnt;
        end
        else if (halfCnt != '1)
        begin
            halfCnt <= halfCnt + SPS_HALF_W'(1);
        end
    end

    // The output clock is rebuilt from sampled edges, so its phase against the pin is loose.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            tx_clock_out <= 1'b0;
        else if (!ctrl.txRate && refEdge)
            tx_clock_out <= refSync[1];
        else if (ctrl.txRate && (refEdge || midTick))
            tx_clock_out <= ~tx_clock_out;
    end

    // Capture clock: both reference edges in half-rate with the reference selected, else the selected rising edge.
    wire txCapRef  = ctrl.txRate ? refEdge : refRise;
    wire txCapture = ctrl.txClkSrc ? txCapRef : txIfRise;

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            tx_word <= '0;
        else
            tx_word <= '{valid: txCapture, data: txCapture ? txDataSync : tx_word.data};
    end

    // Error output moves only on the reference edges of the chosen rate.
    wire errStrobe = ctrl.txRate ? refEdge : refRise;

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            tx_error_flag <= 1'b0;
        else if (errStrobe)
            tx_error_flag <= tx_fault;
    end

    // Receive clock pair: follows the character clock, or halves it.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            rx_interface_clock   <= 1'b0;
            rx_interface_clock_n <= 1'b1;
        end
        else if (!ctrl.rxRate)
        begin
            rx_interface_clock   <= rxRecSync[1];
            rx_interface_clock_n <= ~rxRecSync[1];
        end
        else if (rxRise)
        begin
            rx_interface_clock   <= ~rx_interface_clock;
            rx_interface_clock_n <= rx_interface_clock;
        end
    end

    // Data follows one cycle after the clock pair has moved, so it never races the edge.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            rxTick <= 1'b0;
        else
            rxTick <= rxRise;
    end

    // Self-test display overrides the low bits; bits nine to two stay raw data.
    wire bistShow = (ctrl.selftestCtl == SPS_BIST_SHOW);

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            rx_parallel_data <= 10'h000;
        else if (rxTick)
            rx_parallel_data <= {rxDataSync[9:2], bistShow ? selftest_state[1:0] : rxDataSync[1:0]};
    end

    // Status pin shows the top code bit; held low when the display is off.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            selftest_status_out <= 1'b0;
        else if (!bistShow)
            selftest_status_out <= 1'b0;
        else if (rxTick)
            selftest_status_out <= selftest_state[2];
    end

    // Powered-down flag; not tied to any clock edge of the data path.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            reclocker_powered_down_flag <= 1'b0;
        else
            reclocker_powered_down_flag <= ~(ctrl.reclkOe1 | ctrl.reclkOe2);
    end

    // Event sources: rising edges of the three watched conditions.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            txErrLast <= 1'b0;
            pdownLast <= 1'b0;
            bistLast  <= 1'b0;
        end
        else
        begin
            txErrLast <= tx_error_flag;
            pdownLast <= reclocker_powered_down_flag;
            bistLast  <= selftest_status_out;
        end
    end

    wire [SPS_EV_W-1:0] events = {selftest_status_out & ~bistLast,
                                  reclocker_powered_down_flag & ~pdownLast,
                                  tx_error_flag & ~txErrLast};

    // Register decode.
    wire selStatus  = (reg_addr == SPS_OFF_STATUS);
    wire selMask    = (reg_addr == SPS_OFF_MASK);
    wire selControl = (reg_addr == SPS_OFF_CONTROL);
    wire selState   = (reg_addr == SPS_OFF_STATE);
    wire [SPS_EV_W-1:0] statusClr = (reg_read && selStatus) ? status : '0;

    wire [31:0] readMux = selStatus  ? {29'h0, status} :
                          selMask    ? {29'h0, mask} :
                          selControl ? {25'h0, ctrl} :
                          selState   ? {16'h0, halfLen, 3'h0, rx_interface_clock, tx_clock_out,
                                        reclocker_powered_down_flag, selftest_status_out, tx_error_flag} :
                          32'h0;

    // A set in the cycle of the clearing read survives, so no event is lost.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            status <= '0;
        else
            status <= (status & ~statusClr) | events;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            mask <= '0;
            ctrl <= SPS_CTRL_RESET;
        end
        else if (reg_write && selMask)
            mask <= reg_wdata[SPS_EV_W-1:0];
        else if (reg_write && selControl)
            ctrl <= reg_wdata[SPS_CTRL_W-1:0];
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            reg_rdata <= 32'h0;
        else
            reg_rdata <= reg_read ? readMux : 32'h0;
    end

    assign irq = |(status & mask);

    // Checks on the clock, capture and status behaviour.
    property p_txclk_full;
        @(posedge ref_clk) disable iff (!rst_n)
        (!ctrl.txRate && refRise) |=> tx_clock_out;
    endproperty
    a_txclk_full: assert property (p_txclk_full) else $error("tx clock not high after ref rise");

    property p_txclk_half;
        @(posedge ref_clk) disable iff (!rst_n)
        (ctrl.txRate && $stable(ctrl.txRate) && (refEdge || midTick)) |=> (tx_clock_out != $past(tx_clock_out));
    endproperty
    a_txclk_half: assert property (p_txclk_half) else $error("tx clock did not toggle in half rate");

    property p_txclk_source;
        @(posedge ref_clk) disable iff (!rst_n)
        $changed(tx_clock_out) |-> $past(refEdge || midTick);
    endproperty
    a_txclk_source: assert property (p_txclk_source) else $error("tx clock moved without a tick");

    property p_cap_both;
        @(posedge ref_clk) disable iff (!rst_n)
        (ctrl.txRate && ctrl.txClkSrc && refFall) |=> (tx_word.valid && tx_word.data == $past(txDataSync));
    endproperty
    a_cap_both: assert property (p_cap_both) else $error("half-rate fall edge not captured");

    property p_cap_select;
        @(posedge ref_clk) disable iff (!rst_n)
        (!ctrl.txClkSrc && !txIfRise) |=> !tx_word.valid;
    endproperty
    a_cap_select: assert property (p_cap_select) else $error("capture without selected clock edge");

    property p_err_edge;
        @(posedge ref_clk) disable iff (!rst_n)
        $changed(tx_error_flag) |-> $past(errStrobe);
    endproperty
    a_err_edge: assert property (p_err_edge) else $error("error output moved off reference edge");

    property p_rx_full;
        @(posedge ref_clk) disable iff (!rst_n)
        (!ctrl.rxRate && rxRise) |=> (rx_interface_clock && !rx_interface_clock_n && rxTick)
            ##1 (rx_parallel_data[9:2] == $past(rxDataSync[9:2]));
    endproperty
    a_rx_full: assert property (p_rx_full) else $error("full-rate rx clock or data timing wrong");

    property p_rx_half;
        @(posedge ref_clk) disable iff (!rst_n)
        (ctrl.rxRate && $stable(ctrl.rxRate) && rxRise) |=> ($changed(rx_interface_clock) && rxTick)
            ##1 (rx_parallel_data[9:2] == $past(rxDataSync[9:2]));
    endproperty
    a_rx_half: assert property (p_rx_half) else $error("half-rate rx clock did not toggle");

    property p_bist_low;
        @(posedge ref_clk) disable iff (!rst_n)
        (bistShow && rxTick) |=> (rx_parallel_data[1:0] == $past(selftest_state[1:0]));
    endproperty
    a_bist_low: assert property (p_bist_low) else $error("self-test code missing on low bits");

    property p_bist_pin;
        @(posedge ref_clk) disable iff (!rst_n)
        (bistShow && $stable(ctrl.selftestCtl) && rxTick) |=> (selftest_status_out == $past(selftest_state[2]));
    endproperty
    a_bist_pin: assert property (p_bist_pin) else $error("self-test status pin wrong");

    property p_pdown;
        @(posedge ref_clk) disable iff (!rst_n)
        (!ctrl.reclkOe1 && !ctrl.reclkOe2) [*2] |-> reclocker_powered_down_flag;
    endproperty
    a_pdown: assert property (p_pdown) else $error("powered-down flag not raised");

    property p_sticky;
        @(posedge ref_clk) disable iff (!rst_n)
        events[SPS_EV_PDOWN] |=> status[SPS_EV_PDOWN];
    endproperty
    a_sticky: assert property (p_sticky) else $error("event bit not kept");

    c_half_tx:   cover property (@(posedge ref_clk) disable iff (!rst_n) ctrl.txRate && midTick);
    c_bist_show: cover property (@(posedge ref_clk) disable iff (!rst_n) bistShow && rxTick);
    c_irq:       cover property (@(posedge ref_clk) disable iff (!rst_n) irq && reg_read && selStatus);

endmodule // sps_parallel_port

// File: hw/sps_pkg.sv
// Package for the parallel clocking and status port: register map, field layout,
// reset values and the carrier types shared by the design.
// Assumes a 32-bit register port with word-aligned byte offsets.
package sps_pkg;

    // Register byte offsets.
    localparam logic [3:0] SPS_OFF_STATUS  = 4'h0;
    localparam logic [3:0] SPS_OFF_MASK    = 4'h4;
    localparam logic [3:0] SPS_OFF_CONTROL = 4'h8;
    localparam logic [3:0] SPS_OFF_STATE   = 4'hc;

    // Sticky event bit positions in the status and mask registers.
    localparam int SPS_EV_TXERR = 0;
    localparam int SPS_EV_PDOWN = 1;
    localparam int SPS_EV_BIST  = 2;
    localparam int SPS_EV_W     = 3;

    // Self-test control value that enables the status display.
    localparam logic [1:0] SPS_BIST_SHOW = 2'h2;

    // Width of the half-period measurement counter.
    localparam int SPS_HALF_W = 8;

    // Control register layout, bit 0 first: txRate, rxRate, txClkSrc, reclkOe1, reclkOe2, selftestCtl[1:0].
    typedef struct packed {
        logic [1:0] selftestCtl;   // Receive self-test control.
        logic       reclkOe2;      // Reclocker serial output enable two.
        logic       reclkOe1;      // Reclocker serial output enable one.
        logic       txClkSrc;      // 1 selects the reference clock for capture.
        logic       rxRate;        // 1 selects half-rate receive clocking.
        logic       txRate;        // 1 selects half-rate transmit clocking.
    } sps_ctrl_t;

    localparam int            SPS_CTRL_W     = 7;
    localparam logic [6:0]    SPS_CTRL_RESET = 7'h1c;

    // Captured transmit character.
    typedef struct packed {
        logic       valid;         // One-cycle capture pulse.
        logic [9:0] data;          // Captured character.
    } sps_txword_t;

endpackage

// File: tb/sps_host_model.sv
// Host coprocessor model on the parallel port of the clocking and status block.
// Assumes the bench gates it with run and tells it when self-test display is on.
`timescale 1ns/1ps

module sps_host_model
    import sps_pkg::*;
(
    input  wire logic       run,                 // Lets the interface clock run.
    input  wire logic       selftestOn,          // Self-test display enabled.
    input  wire logic       rx_interface_clock,  // Receive clock from the device.
    input  wire logic [9:0] rx_parallel_data,    // Receive data from the device.
    output logic            tx_interface_clock,  // Transmit interface clock, 80 ns.
    output logic      [9:0] tx_parallel_data,    // Transmit character.
    output logic      [9:0] rxSeen               // What the host keeps of each word.
);
    // The clock stands still low between bursts, as a real host would stop it.
    initial
    begin
        tx_interface_clock = 1'b0;
        tx_parallel_data   = 10'h000;
        rxSeen             = 10'h000;
        forever
        begin
            #40;
            if (run || tx_interface_clock)
                tx_interface_clock = ~tx_interface_clock;
        end
    end

    // Data moves on the falling edge so it is steady across the rising one.
    always @(negedge tx_interface_clock)
        tx_parallel_data <= tx_parallel_data + 10'h001;

    // Upper bits carry raw data, not the self-test code, while self-test is shown, so they are dropped.
    always @(posedge rx_interface_clock)
        rxSeen <= selftestOn ? {8'h00, rx_parallel_data[1:0]} : rx_parallel_data;
endmodule // sps_host_model

// File: tb/serdes_parallel_clocking_status_tb.sv
// Self-checking bench for the parallel clocking and status port.
// Assumes free-running reference and recovered clocks and the host model beside it.
`timescale 1ns/1ps

module serdes_parallel_clocking_status_tb
    import sps_pkg::*;
;
    typedef struct packed {
        logic [6:0] ctl;
        logic [2:0] st;
        logic       pd;
        logic       sp;
    } sps_row_t;

    logic ref_clk, rst_n, tx_reference_clock, tx_fault, rx_recovered_clock;
    logic [9:0] rx_char_data, tx_parallel_data, rx_parallel_data, rxSeen;
    logic [2:0] selftest_state;
    logic [3:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, q;
    logic reg_write, reg_read, irq, tx_clock_out, tx_error_flag, hostRun, hostClk, bistOn;
    logic rx_interface_clock, rx_interface_clock_n, selftest_status_out, reclocker_powered_down_flag;
    sps_txword_t tx_word;
    logic [7:0] cur, prv;
    logic [9:0] prvData;
    int cnt[8];
    int d[8];
    int error_cnt, compares;
    sps_row_t rows[8] = '{'{7'h1c, 3'h7, 1'b0, 1'b0}, '{7'h5c, 3'h5, 1'b0, 1'b1},
                          '{7'h04, 3'h6, 1'b1, 1'b0}, '{7'h44, 3'h6, 1'b1, 1'b1},
                          '{7'h08, 3'h0, 1'b0, 1'b0}, '{7'h10, 3'h1, 1'b0, 1'b0},
                          '{7'h7c, 3'h7, 1'b0, 1'b0}, '{7'h3c, 3'h7, 1'b0, 1'b0}};

    sps_parallel_port i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .tx_reference_clock(tx_reference_clock),
        .tx_interface_clock(hostClk), .tx_parallel_data(tx_parallel_data), .tx_fault(tx_fault),
        .rx_recovered_clock(rx_recovered_clock), .rx_char_data(rx_char_data),
        .selftest_state(selftest_state), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .irq(irq),
        .tx_clock_out(tx_clock_out), .tx_error_flag(tx_error_flag), .tx_word(tx_word),
        .rx_interface_clock(rx_interface_clock), .rx_interface_clock_n(rx_interface_clock_n),
        .rx_parallel_data(rx_parallel_data), .selftest_status_out(selftest_status_out),
        .reclocker_powered_down_flag(reclocker_powered_down_flag));

    sps_host_model i_host (.run(hostRun), .selftestOn(bistOn), .rx_interface_clock(rx_interface_clock),
        .rx_parallel_data(rx_parallel_data), .tx_interface_clock(hostClk),
        .tx_parallel_data(tx_parallel_data), .rxSeen(rxSeen));

    // Clocks: the reference and recovered clocks are offset so no phase is shared.
    initial
    begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    initial
    begin
        tx_reference_clock = 1'b0;
        #1.3;
        forever #20 tx_reference_clock = ~tx_reference_clock;
    end
    initial
    begin
        rx_recovered_clock = 1'b0;
        #3.7;
        forever #40 rx_recovered_clock = ~rx_recovered_clock;
    end

    // A fresh recovered character arrives with every recovered clock rise.
    always @(posedge rx_recovered_clock)
        rx_char_data <= rx_char_data + 10'h03b;

    // Edge counters let the tests measure rates without touching the stimulus.
    assign cur = {3'h0, hostClk, tx_word.valid, rx_interface_clock, tx_clock_out, tx_reference_clock};
    always @(posedge ref_clk)
    begin
        prv     <= cur;
        prvData <= rx_parallel_data;
        for (int i = 0; i < 5; i++)
            if (cur[i] && !prv[i])
                cnt[i] <= cnt[i] + 1;
        if (cur[2] !== prv[2])
            cnt[5] <= cnt[5] + 1;
        if (rx_parallel_data !== prvData)
            cnt[6] <= cnt[6] + 1;
        if (rst_n && rx_interface_clock_n === rx_interface_clock)
            cnt[7] <= cnt[7] + 1;
    end

    task automatic chk(string n, logic [31:0] seen, logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", n, exp, seen);
        end
    endtask

    task automatic near(string n, int v, int e, int t);
        chk(n, (v >= e - t && v <= e + t), 1'b1);
    endtask

    task automatic wr(logic [3:0] a, logic [31:0] v);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_write <= 1'b1;
        @(posedge ref_clk);
        reg_write <= 1'b0;
    endtask

    task automatic rd(logic [3:0] a, output logic [31:0] v);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge ref_clk);
        reg_read <= 1'b0;
        #1 v = reg_rdata;
    endtask

    task automatic span(int n);
        int s[8];
        s = cnt;
        repeat (n) @(posedge ref_clk);
        foreach (d[i]) d[i] = cnt[i] - s[i];
    endtask

    // Lands eight cycles after a recovered rise, once the new word has settled.
    task automatic rxWait();
        @(posedge rx_recovered_clock);
        repeat (8) @(posedge ref_clk);
    endtask

    task automatic report_and_stop();
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // The whole run needs about 4600 cycles; the limit leaves wide slack.
    initial
    begin
        #100000;
        error_cnt++;
        report_and_stop();
    end

    // Main sequence: reset, table of control settings, then hand-written cases.
    initial
    begin
        rst_n = 1'b0; tx_fault = 1'b0; rx_char_data = 10'h000; selftest_state = 3'h0;
        reg_addr = 4'h0; reg_wdata = 32'h0; reg_write = 1'b0; reg_read = 1'b0; hostRun = 1'b0; bistOn = 1'b0;
        foreach (cnt[i]) cnt[i] = 0;
        error_cnt = 0;
        compares = 0;
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd(SPS_OFF_CONTROL, q);
        chk("ctrl_reset", q, {25'h0, SPS_CTRL_RESET});
        rd(SPS_OFF_MASK, q);
        chk("mask_reset", q, 32'h0);
        rd(4'h3, q);
        chk("unmapped", q, 32'h0);
        @(posedge ref_clk);
        #1 chk("rdata_idle", reg_rdata, 32'h0);
        foreach (rows[i])
        begin
            selftest_state <= rows[i].st;
            bistOn         <= (rows[i].ctl[6:5] == SPS_BIST_SHOW);
            wr(SPS_OFF_CONTROL, {25'h0, rows[i].ctl});
            rxWait();
            rxWait();
            chk("pdown", reclocker_powered_down_flag, rows[i].pd);
            chk("st_pin", selftest_status_out, rows[i].sp);
            // The host samples on the true clock rise, so it holds the word launched one rise earlier.
            if (rows[i].ctl[6:5] == SPS_BIST_SHOW)
            begin
                chk("rx_low", rx_parallel_data[1:0], rows[i].st[1:0]);
                chk("host_low", rxSeen, {8'h00, rows[i].st[1:0]});
            end
            else
            begin
                chk("rx_data", rx_parallel_data, rx_char_data);
                chk("host_prev", rxSeen, 10'(rx_char_data - 10'h03b));
            end
        end
        // Rates: every pairing of transmit and receive rate select.
        for (int r = 0; r < 4; r++)
        begin
            wr(SPS_OFF_CONTROL, 32'h1c | r);
            repeat (40) @(posedge ref_clk);
            span(800);
            near("tx_clk", d[1], d[0] * (1 + r[0]), 2);
            near("tx_capt", d[3], d[0] * (1 + r[0]), 2);
            near("rx_clk", d[2], r[1] ? 25 : 50, 1);
            near("rx_upd", d[6], r[1] ? d[5] : d[2], 1);
        end
        // Capture from the host clock, then no capture while it stands still.
        wr(SPS_OFF_CONTROL, 32'h18);
        hostRun <= 1'b1;
        span(800);
        hostRun <= 1'b0;
        repeat (40) @(posedge ref_clk);
        near("if_capt", d[3], d[4], 1);
        chk("if_data", tx_word.data, tx_parallel_data - 10'h001);
        span(100);
        chk("if_still", d[3], 0);
        // Interrupt: sticky error bit, read-only status, masking, read clear.
        selftest_state <= 3'h0;
        rd(SPS_OFF_STATUS, q);
        wr(SPS_OFF_STATUS, 32'h7);
        rd(SPS_OFF_STATUS, q);
        chk("status_ro", q, 32'h0);
        wr(SPS_OFF_MASK, 32'h1);
        tx_fault <= 1'b1;
        repeat (20) @(posedge ref_clk);
        chk("tx_err", tx_error_flag, 1'b1);
        chk("irq_on", irq, 1'b1);
        wr(SPS_OFF_MASK, 32'h6);
        repeat (2) @(posedge ref_clk);
        chk("irq_masked", irq, 1'b0);
        rd(SPS_OFF_STATUS, q);
        chk("status_err", q, 32'h1);
        rd(SPS_OFF_STATUS, q);
        chk("status_clr", q, 32'h0);
        tx_fault <= 1'b0;
        chk("pair", cnt[7], 0);
        // Reset in mid-run restores the control defaults.
        wr(SPS_OFF_CONTROL, 32'h63);
        rst_n <= 1'b0;
        repeat (6) @(posedge ref_clk);
        chk("clk_n_rst", rx_interface_clock_n, 1'b1);
        rst_n <= 1'b1;
        rd(SPS_OFF_CONTROL, q);
        chk("ctrl_rerst", q, {25'h0, SPS_CTRL_RESET});
        report_and_stop();
    end
endmodule // serdes_parallel_clocking_status_tb
